// ---- verilog/three_phase_pwm_timing_core.sv ----
/*
  center-based three-phase pwm timing unit with dead time,
  single/double update and sync pulse; assumes a plain
  register port on core_clk and synchronous sys_rst.
*/
`timescale 1ns/1ps
`include "pwm_timing_regs.svh"

// Function
// R01 - one 10-bit dead time register shared by all pairs
// R02 - off-to-on gap of a pair is dead time times two clocks
// R03 - zero dead time gives no gap
// R04 - mode bit 6 clear single update, set double update
// R05 - reset clears the mode bit
// R06 - single mode one sync per period, rise latches settings
// R07 - sync rise also latches the output segment value
// R08 - double mode adds midpoint sync that relatches everything
// R09 - status bit 3 clear first half, set second half
// R10 - sync pin width is sync width value plus one clocks
// R11 - sync width resets to 0x27
// R12 - three 16-bit duty registers give high side half on-time
// R13 - outputs active low, low means switch on
// R14 - both edges moved away from duty instant by dead time
// R15 - single mode on-times 2(duty-dt) and 2(period-duty-dt)
// R16 - on-times clamped between zero and full period
// R17 - double mode on-times sum the two halves' values
// R18 - pairs b and c built exactly like pair a
// R19 - no outputs, counters stopped until four registers written
// R20 - period value counts clocks in half a period
// R21 - interrupt pulse on each sync pulse
// R22 - reset clears the written record
// R23 - writes go to holding copies, unit uses latched values; the mode bit and sync width are used from their holding registers
module three_phase_pwm_timing_core (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire pwm_timing_pkg::addr_t reg_addr,
  input wire pwm_timing_pkg::data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output pwm_timing_pkg::data_t reg_rdata,
  output logic phase_a_high_out_n,
  output logic phase_a_low_out_n,
  output logic phase_b_high_out_n,
  output logic phase_b_low_out_n,
  output logic phase_c_high_out_n,
  output logic phase_c_low_out_n,
  output logic period_sync_pulse,
  output logic sync_irq,
  output pwm_timing_pkg::seg_t output_segment_act,
  output pwm_timing_pkg::dead_t min_pulse_act,
  output logic timing_run
);
  import pwm_timing_pkg::*;

  // ----------------------------------------
  // holding registers
  // ----------------------------------------
  count_t half_period_reg;
  dead_t dead_time_reg;
  dead_t min_pulse_reg;
  width_t sync_width_reg;
  count_t duty_reg [3];
  seg_t output_segment_reg;
  logic mode_double_r;
  logic [3:0] written_r;
  data_t rdata_r;

  // ----------------------------------------
  // latched copies used by the timing unit
  // ----------------------------------------
  count_t half_period_act;
  dead_t dead_time_act;
  dead_t min_pulse_r;
  count_t duty_act [3];
  seg_t segment_r;

  // ----------------------------------------
  // timing state
  // ----------------------------------------
  logic run_r;
  count_t cnt_r;
  half_t half_r;
  logic sync_r;
  width_t sync_cnt_r;
  logic irq_r;
  logic [2:0] hi_n_r;
  logic [2:0] lo_n_r;

  logic start;
  logic wrap;
  logic latch_evt;
  logic [2:0] hi_n_nxt;
  logic [2:0] lo_n_nxt;

  // ----------------------------------------
  // on-time helpers
  // ----------------------------------------
  // high side half on-time, duty less dead time, clamped
  function automatic count_t on_high(count_t duty, dead_t dt,
                                     count_t tm);
    count_t d;
    d = duty - {6'h00, dt};
    if (duty <= {6'h00, dt}) begin
      on_high = 16'h0000;
    end else if (d >= tm) begin
      on_high = tm;
    end else begin
      on_high = d;
    end
  endfunction

  // low side half on-time, period less duty less dead time
  function automatic count_t on_low(count_t duty, dead_t dt,
                                    count_t tm);
    logic [16:0] s;
    s = {1'b0, duty} + {7'h00, dt};
    if (s >= {1'b0, tm}) begin
      on_low = 16'h0000;
    end else begin
      on_low = tm - s[15:0];
    end
  endfunction

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      half_period_reg <= `HALF_PERIOD_RST;
      dead_time_reg <= `DEAD_TIME_RST;
      min_pulse_reg <= `MIN_PULSE_RST;
      sync_width_reg <= `SYNC_WIDTH_RST; // see R11
      output_segment_reg <= `SEGMENT_RST;
      mode_double_r <= 1'b0; // see R05
    end else if (reg_wr) begin
      unique case (reg_addr)
        `OFS_HALF_PERIOD: begin
          half_period_reg <= reg_wdata; // see R20
        end
        `OFS_DEAD_TIME: begin
          dead_time_reg <= reg_wdata[9:0]; // see R01
        end
        `OFS_MIN_PULSE: begin
          min_pulse_reg <= reg_wdata[9:0];
        end
        `OFS_SYNC_WIDTH: begin
          sync_width_reg <= reg_wdata[7:0];
        end
        `OFS_OUTPUT_SEGMENT: begin
          output_segment_reg <= reg_wdata[8:0];
        end
        `OFS_MODE_CONTROL: begin
          mode_double_r <= reg_wdata[`MODE_DOUBLE_BIT]; // see R04
        end
        default: begin
        end
      endcase
    end
  end

  // duty holding registers, one per pair
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_duty
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          duty_reg[gi] <= `DUTY_RST;
        end else if (reg_wr &&
                     reg_addr == `OFS_DUTY_A + 4'(gi)) begin
          duty_reg[gi] <= reg_wdata; // see R12
        end
      end
    end
  endgenerate

  // record of period and duty writes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      written_r <= 4'h0; // see R22
    end else if (reg_wr) begin
      if (reg_addr == `OFS_HALF_PERIOD) begin
        written_r[0] <= 1'b1;
      end
      if (reg_addr == `OFS_DUTY_A) begin
        written_r[1] <= 1'b1;
      end
      if (reg_addr == `OFS_DUTY_B) begin
        written_r[2] <= 1'b1;
      end
      if (reg_addr == `OFS_DUTY_C) begin
        written_r[3] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  // unmapped indices and idle cycles read as zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `OFS_HALF_PERIOD: rdata_r <= half_period_reg;
        `OFS_DEAD_TIME: rdata_r <= {6'h00, dead_time_reg};
        `OFS_MIN_PULSE: rdata_r <= {6'h00, min_pulse_reg};
        `OFS_SYNC_WIDTH: rdata_r <= {8'h00, sync_width_reg};
        `OFS_DUTY_A: rdata_r <= duty_reg[0];
        `OFS_DUTY_B: rdata_r <= duty_reg[1];
        `OFS_DUTY_C: rdata_r <= duty_reg[2];
        `OFS_OUTPUT_SEGMENT: begin
          rdata_r <= {7'h00, output_segment_reg};
        end
        `OFS_MODE_CONTROL: begin
          rdata_r <= 16'(mode_double_r) << `MODE_DOUBLE_BIT;
        end
        `OFS_SYSTEM_STATUS: begin
          // see R09
          rdata_r <= 16'(half_r == half_second) << `STATUS_HALF_BIT;
        end
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  // ----------------------------------------
  // period sequencing
  // ----------------------------------------
  // a zero half period wraps every clock rather than hanging
  assign wrap = run_r &&
                ({1'b0, cnt_r} + 17'h00001 >= {1'b0, half_period_act});

  // see R19
  assign start = !run_r && (&written_r);

  // see R06 see R08
  assign latch_evt = start ||
                     (wrap && (half_r == half_second || mode_double_r));

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      run_r <= 1'b0;
      cnt_r <= 16'h0000;
      half_r <= half_first;
    end else if (start) begin
      run_r <= 1'b1;
      cnt_r <= 16'h0000;
      half_r <= half_first;
    end else if (wrap) begin
      cnt_r <= 16'h0000;
      // see R09
      half_r <= (half_r == half_first) ? half_second : half_first;
    end else if (run_r) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // latch on sync rise
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      half_period_act <= `HALF_PERIOD_RST;
      dead_time_act <= `DEAD_TIME_RST;
      min_pulse_r <= `MIN_PULSE_RST;
      segment_r <= `SEGMENT_RST;
    end else if (latch_evt) begin
      half_period_act <= half_period_reg; // see R23
      dead_time_act <= dead_time_reg; // see R06
      min_pulse_r <= min_pulse_reg;
      segment_r <= output_segment_reg; // see R07
    end
  end

  generate
    for (gi = 0; gi < 3; gi++) begin : g_duty_act
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          duty_act[gi] <= `DUTY_RST;
        end else if (latch_evt) begin
          duty_act[gi] <= duty_reg[gi]; // see R23 see R08
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // sync pulse and interrupt
  // ----------------------------------------
  // width uses the value being latched on the same edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync_r <= 1'b0;
      sync_cnt_r <= 8'h00;
    end else if (latch_evt) begin
      sync_r <= 1'b1; // see R10
      sync_cnt_r <= sync_width_reg;
    end else if (sync_r) begin
      if (sync_cnt_r == 8'h00) begin
        sync_r <= 1'b0;
      end else begin
        sync_cnt_r <= sync_cnt_r - 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= latch_evt; // see R21
    end
  end

  // ----------------------------------------
  // per-pair edge placement
  // ----------------------------------------
  // first half: low leads, high trails; second half mirrors,
  // so each edge sits dead time off the duty instant
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pair
      count_t t_hi;
      count_t t_lo;
      logic on_hi;
      logic on_lo;
      always_comb begin
        t_hi = on_high(duty_act[gi], dead_time_act,
                       half_period_act); // see R15 see R16
        t_lo = on_low(duty_act[gi], dead_time_act,
                      half_period_act); // see R16
        if (half_r == half_first) begin
          on_hi = cnt_r >= half_period_act - t_hi; // see R14
          on_lo = cnt_r < t_lo; // see R02 see R03
        end else begin
          on_hi = cnt_r < t_hi; // see R17
          on_lo = cnt_r >= half_period_act - t_lo;
        end
        hi_n_nxt[gi] = !(run_r && on_hi); // see R13 see R18
        lo_n_nxt[gi] = !(run_r && on_lo);
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hi_n_r <= 3'b111;
      lo_n_r <= 3'b111;
    end else begin
      hi_n_r <= hi_n_nxt; // see R19
      lo_n_r <= lo_n_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = rdata_r;
  assign phase_a_high_out_n = hi_n_r[0];
  assign phase_a_low_out_n = lo_n_r[0];
  assign phase_b_high_out_n = hi_n_r[1];
  assign phase_b_low_out_n = lo_n_r[1];
  assign phase_c_high_out_n = hi_n_r[2];
  assign phase_c_low_out_n = lo_n_r[2];
  assign period_sync_pulse = sync_r;
  assign sync_irq = irq_r;
  assign output_segment_act = segment_r;
  assign min_pulse_act = min_pulse_r;
  assign timing_run = run_r;

endmodule

// ---- verilog/pwm_timing_regs.svh ----
/*
  register indices, field positions, reset values of the
  three-phase timing core; assumes include by bare name.
*/
`ifndef PWM_TIMING_REGS_SVH
`define PWM_TIMING_REGS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define OFS_HALF_PERIOD 4'h0
`define OFS_DEAD_TIME 4'h1
`define OFS_MIN_PULSE 4'h2
`define OFS_SYNC_WIDTH 4'h3
`define OFS_DUTY_A 4'h4
`define OFS_DUTY_B 4'h5
`define OFS_DUTY_C 4'h6
`define OFS_OUTPUT_SEGMENT 4'h7
`define OFS_MODE_CONTROL 4'h8
`define OFS_SYSTEM_STATUS 4'h9

// ----------------------------------------
// fields
// ----------------------------------------
`define MODE_DOUBLE_BIT 6
`define STATUS_HALF_BIT 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define HALF_PERIOD_RST 16'h0000
`define DEAD_TIME_RST 10'h000
`define MIN_PULSE_RST 10'h000
`define SYNC_WIDTH_RST 8'h27
`define DUTY_RST 16'h0000
`define SEGMENT_RST 9'h000

`endif

// ---- verilog/pwm_timing_pkg.sv ----
/*
  types of the three-phase timing core;
  assumes nothing of its surroundings.
*/
package pwm_timing_pkg;
  typedef logic [15:0] count_t;
  typedef logic [9:0] dead_t;
  typedef logic [7:0] width_t;
  typedef logic [8:0] seg_t;
  typedef logic [3:0] addr_t;
  typedef logic [15:0] data_t;
  typedef enum logic {half_first, half_second} half_t;
endpackage

// ---- bench/pwm_core_asserts.sv ----
/*
  port assertions of the timing core.
  assumes one clock and the sync reset.
*/
`timescale 1ns/1ps
module pwm_core_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic phase_a_high_out_n,
  input wire logic phase_a_low_out_n,
  input wire logic phase_b_high_out_n,
  input wire logic phase_b_low_out_n,
  input wire logic phase_c_high_out_n,
  input wire logic phase_c_low_out_n,
  input wire logic period_sync_pulse,
  input wire logic sync_irq,
  input wire logic timing_run
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic all_off;
  assign all_off = &{phase_a_high_out_n, phase_a_low_out_n, phase_b_high_out_n,
    phase_b_low_out_n, phase_c_high_out_n, phase_c_low_out_n};
  property p_idle; !timing_run |-> all_off; endproperty
  property p_rst;
    disable iff (1'b0) sys_rst |=> !timing_run && all_off && !period_sync_pulse && !sync_irq;
  endproperty
  property p_irq; $rose(period_sync_pulse) |-> sync_irq; endproperty
  property p_src; sync_irq |-> $rose(period_sync_pulse); endproperty
  property p_start; $rose(timing_run) |-> period_sync_pulse && sync_irq; endproperty
  property p_hold; timing_run |=> timing_run; endproperty
  property p_gap_a; phase_a_high_out_n || phase_a_low_out_n; endproperty
  property p_gap_b; phase_b_high_out_n || phase_b_low_out_n; endproperty
  property p_gap_c; phase_c_high_out_n || phase_c_low_out_n; endproperty
  a_idle: assert property (p_idle) else $error("on while stopped");
  a_rst: assert property (p_rst) else $error("reset");
  a_irq: assert property (p_irq) else $error("no irq");
  a_src: assert property (p_src) else $error("stray irq");
  a_start: assert property (p_start) else $error("no start sync");
  a_hold: assert property (p_hold) else $error("run dropped");
  a_gap_a: assert property (p_gap_a) else $error("pair a both on");
  a_gap_b: assert property (p_gap_b) else $error("pair b both on");
  a_gap_c: assert property (p_gap_c) else $error("pair c both on");
  c_start: cover property ($rose(timing_run));
  c_dbl: cover property (sync_irq ##[2:20] sync_irq);
  c_low: cover property ($fell(phase_c_low_out_n));
endmodule

bind three_phase_pwm_timing_core pwm_core_asserts u_chk (.core_clk(core_clk),
  .sys_rst(sys_rst), .phase_a_high_out_n(phase_a_high_out_n),
  .phase_a_low_out_n(phase_a_low_out_n), .phase_b_high_out_n(phase_b_high_out_n),
  .phase_b_low_out_n(phase_b_low_out_n), .phase_c_high_out_n(phase_c_high_out_n),
  .phase_c_low_out_n(phase_c_low_out_n), .period_sync_pulse(period_sync_pulse),
  .sync_irq(sync_irq), .timing_run(timing_run));

// ---- bench/gate_drive_model.sv ----
/*
  gate drivers and switches: counts on cycles per output, flags a leg short.
  assumes the core's clock.
*/
`timescale 1ns/1ps
module gate_drive_model (
  input wire logic core_clk,
  input wire logic clr,
  input wire logic [5:0] gate_n,
  output logic [15:0] on_cnt [6],
  output logic shoot
);
  // ----
  // switches
  // ----
  // low command closes the switch
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 6; i++) begin
      on_cnt[i] <= clr ? 16'h0000 : on_cnt[i] + 16'(!gate_n[i]);
    end
  end
  // sticky: a short lasting one cycle is still fatal
  always_ff @(posedge core_clk) begin
    shoot <= !clr && (shoot || !(gate_n[5] | gate_n[4]) || !(gate_n[3] | gate_n[2])
      || !(gate_n[1] | gate_n[0]));
  end
endmodule

// ---- bench/tb_three_phase_pwm_timing_core.sv ----
/*
  bench of the timing core: register tasks, on-time checks.
  assumes the design package and the gate model.
*/
`timescale 1ns/1ps
module tb_three_phase_pwm_timing_core;
  import pwm_timing_pkg::*;
  logic core_clk, sys_rst, reg_wr, reg_rd, clr;
  addr_t reg_addr;
  data_t reg_wdata, reg_rdata, v, s;
  wire [5:0] gate_n;
  wire sync, irq, run, shoot;
  seg_t seg;
  dead_t mp;
  logic [15:0] on_cnt [6];
  int n_errors, n_checks, sync_hi, sync_n;
  three_phase_pwm_timing_core dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .phase_a_high_out_n(gate_n[5]), .phase_a_low_out_n(gate_n[4]),
    .phase_b_high_out_n(gate_n[3]), .phase_b_low_out_n(gate_n[2]),
    .phase_c_high_out_n(gate_n[1]), .phase_c_low_out_n(gate_n[0]),
    .period_sync_pulse(sync), .sync_irq(irq), .output_segment_act(seg),
    .min_pulse_act(mp), .timing_run(run));
  gate_drive_model gdm (.core_clk(core_clk), .clr(clr), .gate_n(gate_n),
    .on_cnt(on_cnt), .shoot(shoot));
  // ----
  // tasks
  // ----
  always @(posedge core_clk) begin
    sync_hi <= clr ? 0 : sync_hi + int'(sync);
    sync_n <= clr ? 0 : sync_n + int'(irq);
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input data_t e, input data_t g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // strobes never lowered here, so back-to-back calls assign once per step
  task automatic acc(input logic w, input logic r, input addr_t a, input data_t d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask
  task automatic rd(input addr_t a);
    acc(1'b0, 1'b1, a, 16'h0000);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic wirq();
    int i;
    for (i = 0; i < 200; i++) begin
      @(negedge core_clk);
      if (irq === 1'b1) break;
    end
    if (i == 200) begin
      chk("irq wait", 16'h0001, 16'h0000);
      finish_test();
    end
    @(posedge core_clk);
  endtask
  function automatic int cl(input int x, input int tm);
    return x < 0 ? 0 : (x > tm ? tm : x);
  endfunction
  task automatic cfgm(input int tm, dt, a, b, c, sw, dbl);
    data_t w [9];
    int d [3];
    w = '{16'(tm), 16'(dt) | 16'hfc00, 16'h0155, 16'(sw), 16'(a), 16'(b), 16'(c),
      16'h01a5, dbl ? 16'h0040 : 16'h0000};
    d = '{a, b, c};
    for (int i = 0; i < 9; i++) acc(1'b1, 1'b0, 4'(i), w[i]);
    acc(1'b0, 1'b0, 4'h0, 16'h0000);
    repeat (40) @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (2 * tm) @(posedge core_clk);
    @(negedge core_clk);
    for (int i = 0; i < 3; i++) begin
      chk("high on", 16'(2 * cl(d[i] - dt, tm)), on_cnt[5 - 2 * i]);
      chk("low on", 16'(2 * cl(tm - d[i] - dt, tm)), on_cnt[4 - 2 * i]);
    end
    chk("syncs", 16'(dbl + 1), 16'(sync_n));
    chk("sync cycles", 16'((dbl + 1) * (sw + 1)), 16'(sync_hi));
    chk("short", 16'h0000, 16'(shoot));
    chk("segment", 16'h01a5, 16'(seg));
    chk("min pulse", 16'h0155, 16'(mp));
    chk("run", 16'h0001, 16'(run));
    @(posedge core_clk);
  endtask
  // reset values, then three of four needed writes
  task automatic fresh();
    rd(4'h3);
    chk("sync width", 16'h0027, v);
    rd(4'h8);
    chk("mode", 16'h0000, v);
    rd(4'hc);
    chk("unmapped", 16'h0000, v);
    acc(1'b1, 1'b0, 4'h0, 16'h0008);
    acc(1'b1, 1'b0, 4'h4, 16'h0005);
    acc(1'b1, 1'b0, 4'h5, 16'h0003);
    acc(1'b0, 1'b0, 4'h0, 16'h0000);
    repeat (30) @(posedge core_clk);
    chk("run", 16'h0000, 16'(run));
  endtask
  // ----
  // sequence
  // ----
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    clr = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    fresh();
    cfgm(8, 1, 5, 3, 8, 0, 0);
    rd(4'h1);
    chk("dead time", 16'h0001, v);
    wirq();
    rd(4'h9);
    chk("status", 16'h0000, v & 16'h0008);
    cfgm(6, 0, 0, 6, 2, 2, 0);
    cfgm(6, 0, 0, 6, 2, 2, 1);
    rd(4'h8);
    chk("mode", 16'h0040, v);
    wirq();
    rd(4'h9);
    s = v;
    wirq();
    rd(4'h9);
    chk("half flip", 16'h0008, (v ^ s) & 16'h0008);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    fresh();
    finish_test();
  end
endmodule
